// >>> logic/afesc_out_path.sv
// Output word path: polarity, latency line and word multiplexing.
// Assumes tick marks one converter period and phase counts master clocks
// within it; flush clears the latency line.

`timescale 1ns/10ps
`default_nettype none

module afesc_out_path #(
	parameter int WIDTH     = 12,
	parameter int MAX_DELAY = 3
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              flush,
	input  wire logic              tick,
	input  wire logic [1:0]        phase,
	input  wire logic [WIDTH-1:0]  pixel_in,
	input  wire logic              invert,
	input  wire logic [1:0]        delay,
	input  wire logic [1:0]        format,
	output logic      [WIDTH-1:0]  data_out
);

	// =========================================================
	// Elaboration checks
	if (WIDTH != 12) begin : g_bad_width
		$error("afesc_out_path: word split needs WIDTH of 12");
	end
	if (MAX_DELAY != 3) begin : g_bad_delay
		$error("afesc_out_path: delay code spans exactly 3 stages");
	end

	// =========================================================
	// Latency line, one stage per converter period
	logic [WIDTH-1:0] stage [MAX_DELAY+1];
	logic [WIDTH-1:0] chosen;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage[0] <= 12'h000;
		end else if (flush) begin
			stage[0] <= 12'h000;
		end else if (tick) begin
			stage[0] <= invert ? ~pixel_in : pixel_in;
		end
	end

	for (genvar i = 1; i <= MAX_DELAY; i++) begin : g_stage
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				stage[i] <= 12'h000;
			end else if (flush) begin
				stage[i] <= 12'h000;
			end else if (tick) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign chosen = stage[delay];

	// split word by format, high part first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= 12'h000;
		end else begin
			case (format)
				afesc_pkg::AFESC_FMT_8_4: begin
					data_out <= (phase == 2'h0) ? {chosen[11:4], 4'h0}
					                            : {chosen[3:0], 8'h00};
				end
				afesc_pkg::AFESC_FMT_6_6: begin
					data_out <= (phase == 2'h0) ? chosen
					                            : {chosen[5:0], 6'h00};
				end
				afesc_pkg::AFESC_FMT_4_4_4: begin
					// Third nibble needs a three-clock period
					case (phase)
						2'h0:    data_out <= chosen;
						2'h1:    data_out <= {chosen[7:0], 4'h0};
						default: data_out <= {chosen[3:0], 8'h00};
					endcase
				end
				default: begin
					data_out <= chosen;
				end
			endcase
		end
	end

	// =========================================================
	// Checks
	// zero-latency parallel word follows input polarity
	chk_invert_word: assert property (
		@(posedge clk) disable iff (rst)
		tick && !flush && format == 2'h0 && delay == 2'h0
			&& $stable(invert) ##1 $stable(invert) && !flush
			&& format == 2'h0 && delay == 2'h0
		|=> data_out == ($past(pixel_in, 2) ^ {WIDTH{$past(invert, 2)}}))
		else $error("output word polarity wrong");

	cov_inverted: cover property (@(posedge clk) disable iff (rst)
		tick && invert && delay == 2'h3);

endmodule : afesc_out_path

`default_nettype wire

// >>> logic/afesc_pkg.sv
// Constants, field layouts and carrier types of the setup register bank.
// Assumes a single master clock domain and a six-bit register address port.
//
// Contract
// - Global active bit clear powers whole device down; set keeps it active.
// - Double-sampling bit set selects correlated sampling, clear selects single-ended.
// - Monochrome bit clear means colour, set means monochrome operation.
// - Per-block power-down enable lets per-block disable bits switch blocks off.
// - Offset code 00/01 zero output, 10 full positive, 11 full negative.
// - Format code selects 12-bit, 8+4, 6+6 or 4+4+4 output words; 4+4+4 sends its third part only in fast line mode.
// - Invert bit set digitally inverts output code; clear follows video polarity.
// - External reference bit powers clamp DAC down and floats its output.
// - DAC span bit set spans to top reference, clear spans to supply.
// - Delay code adds zero to three converter periods of output latency.
// - Converter period is two master clocks, three in fast line mode.
// - Four-bit clamp level value, default 1111, sets clamp DAC output.
// - Reset timing code shifts reset sample: advance, nominal, retard one, two.
// - Channel code picks red, green, blue; code 11 is reserved.
// - Any write to soft reset location resets all internal cells; the code leaves reg_rdata at its last value.
// - Any write to colour cycle reset returns colour counter to red.
// - Line-sequential bit clear is normal, set is line-by-line colour.
// - Line-by-line forces mono on, channel 00, green and blue gain off.

package afesc_pkg;

	// =========================================================
	// Register addresses
	localparam logic [5:0] ADDR_POWER_SAMPLING = 6'h01;
	localparam logic [5:0] ADDR_OUTPUT_FORMAT  = 6'h02;
	localparam logic [5:0] ADDR_REF_CHANNEL    = 6'h03;
	localparam logic [5:0] ADDR_SOFT_RESET     = 6'h04;
	localparam logic [5:0] ADDR_COLOUR_RESET   = 6'h05;
	localparam logic [5:0] ADDR_LINE_SEQ       = 6'h06;
	localparam logic [5:0] ADDR_REVISION       = 6'h07;
	localparam logic [5:0] ADDR_BLOCK_DISABLE  = 6'h09;

	// =========================================================
	// Values after reset
	localparam logic [7:0] RST_POWER_SAMPLING = 8'h03;
	localparam logic [7:0] RST_OUTPUT_FORMAT  = 8'h20;
	localparam logic [7:0] RST_REF_CHANNEL    = 8'h1f;
	localparam logic [7:0] RST_LINE_SEQ       = 8'h00;
	localparam logic [7:0] RST_BLOCK_DISABLE  = 8'h00;

	// =========================================================
	// Field positions
	localparam int BIT_ACTIVE      = 0;
	localparam int BIT_DOUBLE_SMP  = 1;
	localparam int BIT_MONO        = 2;
	localparam int BIT_PER_BLK_EN  = 3;
	localparam int POS_FS_OFFSET   = 4;
	localparam int BIT_MAX_SPEED   = 6;
	localparam int POS_OUT_FORMAT  = 0;
	localparam int BIT_INVERT      = 2;
	localparam int BIT_EXT_REF     = 3;
	localparam int BIT_DAC_SPAN    = 5;
	localparam int POS_OUT_DELAY   = 6;
	localparam int POS_CLAMP_LEVEL = 0;
	localparam int POS_RST_TIMING  = 4;
	localparam int POS_CHANNEL     = 6;
	localparam int BIT_LINE_SEQ    = 0;

	// Writable bit masks; unlisted bits read as zero
	localparam logic [7:0] MASK_POWER_SAMPLING = 8'h7f;
	localparam logic [7:0] MASK_OUTPUT_FORMAT  = 8'hef;
	localparam logic [7:0] MASK_BLOCK_DISABLE  = 8'h0f;

	// =========================================================
	// Converter clock period in master clocks
	localparam logic [1:0] ADC_PERIOD_NORMAL = 2'h2;
	localparam logic [1:0] ADC_PERIOD_FAST   = 2'h3;

	// =========================================================
	// Codes
	typedef enum logic [1:0] {
		AFESC_FMT_PARALLEL = 2'h0,
		AFESC_FMT_8_4      = 2'h1,
		AFESC_FMT_6_6      = 2'h2,
		AFESC_FMT_4_4_4    = 2'h3
	} afesc_format_type;

	typedef enum logic [1:0] {
		AFESC_OFS_ZERO = 2'h0,
		AFESC_OFS_POS  = 2'h1,
		AFESC_OFS_NEG  = 2'h2
	} afesc_offset_type;

	// Colour auto-cycle position, one-hot
	typedef enum logic [2:0] {
		AFESC_COL_RED   = 3'h1,
		AFESC_COL_GREEN = 3'h2,
		AFESC_COL_BLUE  = 3'h4
	} afesc_colour_type;

	// Decoded analogue controls handed to the front end
	typedef struct packed {
		logic             device_active;
		logic             double_sample;
		logic             mono;
		logic [1:0]       mono_channel;
		logic [3:0]       block_off;      // adc, blue, green, red
		afesc_offset_type offset_mode;
		logic             max_speed;
		logic             clamp_dac_oe_n;
		logic             clamp_span_top;
		logic [3:0]       clamp_level;
		logic [1:0]       reset_timing;
	} afesc_ctrl_type;

endpackage : afesc_pkg

// >>> logic/afesc_regs.sv
// Setup register bank of an image-sensor digitiser: register port,
// decoded analogue controls, converter clock, colour counter, output path.
// Assumes register writes and reads are single-cycle strobes on clk.

`timescale 1ns/10ps
`default_nettype none

module afesc_regs #(
	parameter logic [7:0] REVISION = 8'h00,  // Arbitrary revision value
	parameter int         WIDTH    = 12
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic [5:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_write,
	input  wire logic                      reg_read,
	output logic      [7:0]                reg_rdata,
	input  wire logic                      fast_line_mode,
	input  wire logic                      colour_advance,
	input  wire logic [WIDTH-1:0]          pixel_in,
	output afesc_pkg::afesc_ctrl_type      ctrl,
	output afesc_pkg::afesc_colour_type    colour_sel,
	output logic                           adc_tick,
	output logic      [WIDTH-1:0]          data_out
);

	// =========================================================
	// Elaboration check
	if (WIDTH != 12) begin : g_bad_width
		$error("afesc_regs: pixel word must be 12 bits");
	end

	// =========================================================
	// Address decode
	function automatic logic hit(input logic [5:0] addr,
	                             input logic [5:0] target);
		hit = reg_write && (addr == target);
	endfunction : hit

	logic soft_reset;
	logic colour_reset;

	assign soft_reset   = hit(reg_addr, afesc_pkg::ADDR_SOFT_RESET);
	assign colour_reset = hit(reg_addr, afesc_pkg::ADDR_COLOUR_RESET);

	// =========================================================
	// Setup registers
	logic [7:0] power_and_sampling_setup;
	logic [7:0] output_format_setup;
	logic [7:0] reference_and_channel_setup;
	logic [7:0] line_sequential_setup;
	logic [7:0] block_disable_setup;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_and_sampling_setup <= afesc_pkg::RST_POWER_SAMPLING;
		end else if (soft_reset) begin
			power_and_sampling_setup <= afesc_pkg::RST_POWER_SAMPLING;
		end else if (hit(reg_addr, afesc_pkg::ADDR_POWER_SAMPLING)) begin
			power_and_sampling_setup <=
				reg_wdata & afesc_pkg::MASK_POWER_SAMPLING;
		end
	end

	// Bit 4 has no function and stays zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			output_format_setup <= afesc_pkg::RST_OUTPUT_FORMAT;
		end else if (soft_reset) begin
			output_format_setup <= afesc_pkg::RST_OUTPUT_FORMAT;
		end else if (hit(reg_addr, afesc_pkg::ADDR_OUTPUT_FORMAT)) begin
			output_format_setup <= reg_wdata & afesc_pkg::MASK_OUTPUT_FORMAT;
		end
	end

	// Reference level, reset timing and channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reference_and_channel_setup <= afesc_pkg::RST_REF_CHANNEL;
		end else if (soft_reset) begin
			reference_and_channel_setup <= afesc_pkg::RST_REF_CHANNEL;
		end else if (hit(reg_addr, afesc_pkg::ADDR_REF_CHANNEL)) begin
			reference_and_channel_setup <= reg_wdata;
		end
	end

	// Upper bits kept for readback only; they steer nothing here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_sequential_setup <= afesc_pkg::RST_LINE_SEQ;
		end else if (soft_reset) begin
			line_sequential_setup <= afesc_pkg::RST_LINE_SEQ;
		end else if (hit(reg_addr, afesc_pkg::ADDR_LINE_SEQ)) begin
			line_sequential_setup <= reg_wdata;
		end
	end

	// Per-block disable bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			block_disable_setup <= afesc_pkg::RST_BLOCK_DISABLE;
		end else if (soft_reset) begin
			block_disable_setup <= afesc_pkg::RST_BLOCK_DISABLE;
		end else if (hit(reg_addr, afesc_pkg::ADDR_BLOCK_DISABLE)) begin
			block_disable_setup <= reg_wdata & afesc_pkg::MASK_BLOCK_DISABLE;
		end
	end

	// =========================================================
	// Readback, registered; strobes and unmapped addresses read zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				afesc_pkg::ADDR_POWER_SAMPLING: reg_rdata <= power_and_sampling_setup;
				afesc_pkg::ADDR_OUTPUT_FORMAT:  reg_rdata <= output_format_setup;
				afesc_pkg::ADDR_REF_CHANNEL:    reg_rdata <= reference_and_channel_setup;
				afesc_pkg::ADDR_LINE_SEQ:       reg_rdata <= line_sequential_setup;
				afesc_pkg::ADDR_REVISION:       reg_rdata <= REVISION;
				afesc_pkg::ADDR_BLOCK_DISABLE:  reg_rdata <= block_disable_setup;
				default:                        reg_rdata <= 8'h00;
			endcase
		end
	end

	// =========================================================
	// Field decode
	logic       active;
	logic       line_seq;
	logic [1:0] fs_code;
	logic [1:0] format;
	logic [1:0] delay;
	logic       invert;

	assign active   = power_and_sampling_setup[afesc_pkg::BIT_ACTIVE];
	assign line_seq = line_sequential_setup[afesc_pkg::BIT_LINE_SEQ];
	assign fs_code  = power_and_sampling_setup[afesc_pkg::POS_FS_OFFSET +: 2];
	assign format   = output_format_setup[afesc_pkg::POS_OUT_FORMAT +: 2];
	assign delay    = output_format_setup[afesc_pkg::POS_OUT_DELAY +: 2];
	assign invert   = output_format_setup[afesc_pkg::BIT_INVERT];

	// Controls to the analogue side, straight from register flops
	always_comb begin
		ctrl = '0;
		ctrl.device_active = active;
		ctrl.double_sample =
			power_and_sampling_setup[afesc_pkg::BIT_DOUBLE_SMP];
		// mono or colour, forced in line mode
		ctrl.mono = power_and_sampling_setup[afesc_pkg::BIT_MONO] | line_seq;
		// channel code, forced to red in line mode
		ctrl.mono_channel = line_seq ? 2'h0 :
			reference_and_channel_setup[afesc_pkg::POS_CHANNEL +: 2];
		// per-block off only when enabled, all off when inactive
		for (int b = 0; b < 4; b++) begin
			ctrl.block_off[b] = !active ||
				(power_and_sampling_setup[afesc_pkg::BIT_PER_BLK_EN]
				 && block_disable_setup[b]);
		end
		// green and blue gain off in line mode
		if (line_seq) begin
			ctrl.block_off[1] = 1'b1;
			ctrl.block_off[2] = 1'b1;
		end
		case (fs_code)
			2'h2:    ctrl.offset_mode = afesc_pkg::AFESC_OFS_POS;
			2'h3:    ctrl.offset_mode = afesc_pkg::AFESC_OFS_NEG;
			default: ctrl.offset_mode = afesc_pkg::AFESC_OFS_ZERO;
		endcase
		ctrl.max_speed = power_and_sampling_setup[afesc_pkg::BIT_MAX_SPEED];
		// external reference floats the clamp DAC
		ctrl.clamp_dac_oe_n = !active ||
			output_format_setup[afesc_pkg::BIT_EXT_REF];
		ctrl.clamp_span_top = output_format_setup[afesc_pkg::BIT_DAC_SPAN];
		ctrl.clamp_level =
			reference_and_channel_setup[afesc_pkg::POS_CLAMP_LEVEL +: 4];
		ctrl.reset_timing =
			reference_and_channel_setup[afesc_pkg::POS_RST_TIMING +: 2];
	end

	// =========================================================
	// Converter clock divider; stops while powered down
	logic [1:0] phase;
	logic [1:0] period;

	// two or three master clocks per period
	assign period   = fast_line_mode ? afesc_pkg::ADC_PERIOD_FAST
	                                 : afesc_pkg::ADC_PERIOD_NORMAL;
	assign adc_tick = active && (phase == period - 2'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 2'h0;
		end else if (soft_reset || !active || phase >= period - 2'h1) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// =========================================================
	// Colour auto-cycle counter, red then green then blue
	afesc_pkg::afesc_colour_type next_colour;

	always_comb begin
		case (colour_sel)
			afesc_pkg::AFESC_COL_RED:   next_colour = afesc_pkg::AFESC_COL_GREEN;
			afesc_pkg::AFESC_COL_GREEN: next_colour = afesc_pkg::AFESC_COL_BLUE;
			default:                    next_colour = afesc_pkg::AFESC_COL_RED;
		endcase
	end

	// restart wins over an advance in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			colour_sel <= afesc_pkg::AFESC_COL_RED;
		end else if (soft_reset || colour_reset) begin
			colour_sel <= afesc_pkg::AFESC_COL_RED;
		end else if (colour_advance) begin
			colour_sel <= next_colour;
		end
	end

	// =========================================================
	// Output word path
	afesc_out_path #(
		.WIDTH     (WIDTH),
		.MAX_DELAY (3)
	) u_out_path (
		.clk      (clk),
		.rst      (rst),
		.flush    (soft_reset || !active),
		.tick     (adc_tick),
		.phase    (phase),
		.pixel_in (pixel_in),
		.invert   (invert),
		.delay    (delay),
		.format   (format),
		.data_out (data_out)
	);

	// =========================================================
	// Checks
	chk_soft_reset_defaults: assert property (
		@(posedge clk) disable iff (rst)
		soft_reset |=> power_and_sampling_setup == 8'h03
			&& output_format_setup == 8'h20
			&& reference_and_channel_setup == 8'h1f
			&& line_sequential_setup == 8'h00)
		else $error("soft reset left a setup field off default");

	chk_power_down_all: assert property (
		@(posedge clk) disable iff (rst)
		hit(reg_addr, 6'h01) && !reg_wdata[0]
		|=> !ctrl.device_active && ctrl.block_off == 4'hf
			&& !adc_tick [*2])
		else $error("power down did not stop the device");

	chk_sampling_mode: assert property (
		@(posedge clk) disable iff (rst)
		hit(reg_addr, 6'h01) |=> ctrl.double_sample == $past(reg_wdata[1]))
		else $error("sampling mode does not follow write");

	chk_line_forces_mono: assert property (
		@(posedge clk) disable iff (rst)
		line_seq |-> ctrl.mono && ctrl.mono_channel == 2'h0
			&& ctrl.block_off[2:1] == 2'h3)
		else $error("line mode did not force mono red");

	chk_tick_normal: assert property (
		@(posedge clk) disable iff (rst)
		adc_tick && !fast_line_mode && !soft_reset
			##1 (active && !fast_line_mode && !soft_reset)
			##1 (active && !fast_line_mode)
		|-> adc_tick && !$past(adc_tick))
		else $error("normal converter period is not two clocks");

	chk_tick_fast: assert property (
		@(posedge clk) disable iff (rst)
		adc_tick && fast_line_mode && !soft_reset
			##1 (active && fast_line_mode && !soft_reset) [*2]
			##1 (active && fast_line_mode)
		|-> adc_tick && !$past(adc_tick) && !$past(adc_tick, 2))
		else $error("fast converter period is not three clocks");

	chk_colour_restart: assert property (
		@(posedge clk) disable iff (rst)
		colour_reset |=> colour_sel == afesc_pkg::AFESC_COL_RED)
		else $error("colour counter not back at red");

	chk_ext_ref_float: assert property (
		@(posedge clk) disable iff (rst)
		hit(reg_addr, 6'h02) && reg_wdata[3] |=> ctrl.clamp_dac_oe_n)
		else $error("clamp DAC still driven with external reference");

	chk_offset_code: assert property (
		@(posedge clk) disable iff (rst)
		hit(reg_addr, 6'h01) && reg_wdata[5:4] == 2'h3
		|=> ctrl.offset_mode == afesc_pkg::AFESC_OFS_NEG)
		else $error("negative offset code not decoded");

	cov_soft_reset: cover property (@(posedge clk) disable iff (rst)
		soft_reset);
	cov_fast_line: cover property (@(posedge clk) disable iff (rst)
		adc_tick && fast_line_mode && line_seq);
	cov_colour_wrap: cover property (@(posedge clk) disable iff (rst)
		colour_sel == afesc_pkg::AFESC_COL_BLUE && colour_advance);

endmodule : afesc_regs

`default_nettype wire

// >>> verif/afesc_pixel_source.sv
// Pixel source standing in for the sensor side of the digitiser.
// Assumes adc_tick marks one converter period of the device.
`timescale 1ns/10ps
`default_nettype none

module afesc_pixel_source (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        adc_tick,
	input  wire logic [11:0] word,
	output logic      [11:0] pixel_in
);
	// ==================================================
	// Word presenter
	// New code only after a sampling edge, so each
	// converter period sees one stable code throughout
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pixel_in <= 12'h000;
		end else if (adc_tick) begin
			pixel_in <= word;
		end
	end
endmodule : afesc_pixel_source
`default_nettype wire

// >>> verif/afesc_regs_bench.sv
// Self-checking bench of the setup register bank.
// Assumes afesc_pkg, the design and the pixel source compiled first.
`timescale 1ns/10ps
`default_nettype none

module afesc_regs_bench;
	logic                        clk = 1'b0;
	logic                        rst = 1'b1;
	logic [5:0]                  reg_addr = 6'h00;
	logic [7:0]                  reg_wdata = 8'h00;
	logic                        reg_write = 1'b0;
	logic                        reg_read = 1'b0;
	logic                        fast_line_mode = 1'b0;
	logic                        colour_advance = 1'b0;
	logic [11:0]                 word = 12'h000;
	logic [7:0]                  reg_rdata;
	logic [11:0]                 pixel_in;
	logic                        adc_tick;
	logic [11:0]                 data_out;
	afesc_pkg::afesc_ctrl_type   ctrl;
	afesc_pkg::afesc_colour_type colour_sel;
	logic [31:0]                 seed = 32'h0000_6220;
	int                          mismatches = 0;
	int                          samples_checked = 0;
	// Random pass: address, bits kept legal, bits that read back
	logic [4:0][5:0] regs  = {6'h01, 6'h02, 6'h03, 6'h06, 6'h09};
	logic [4:0][7:0] keeps = {8'hbf, 8'hff, 8'hbf, 8'hfe, 8'hff};
	logic [4:0][7:0] masks = {8'h7f, 8'hef, 8'hff, 8'hff, 8'h0f};

	// ==================================================
	// Clock, design and pixel source
	always #4 clk = ~clk;

	afesc_regs #(.REVISION(8'h5a)) u_dut ( // Revision value arbitrary
		.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.fast_line_mode(fast_line_mode), .colour_advance(colour_advance),
		.pixel_in(pixel_in), .ctrl(ctrl), .colour_sel(colour_sel),
		.adc_tick(adc_tick), .data_out(data_out)
	);
	afesc_pixel_source u_src (
		.clk(clk), .rst(rst), .adc_tick(adc_tick),
		.word(word), .pixel_in(pixel_in)
	);

	// ==================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Inputs always move 1 ns after the rising edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	task automatic chk8(input logic [7:0] got, input logic [7:0] e);
		samples_checked++;
		if (got !== e) begin
			mismatches++;
			$display("unexpected at %0t: byte %h want %h", $time, got, e);
		end
	endtask : chk8

	task automatic chk12(input logic [11:0] got, input logic [11:0] e);
		samples_checked++;
		if (got !== e) begin
			mismatches++;
			$display("unexpected at %0t: word %h want %h", $time, got, e);
		end
	endtask : chk12

	// Strobe dropped and one idle edge, so calls never collide
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		step();
		reg_write = 1'b0;
		step();
	endtask : wr

	task automatic chkrd(input logic [5:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_read = 1'b1;
		step();
		reg_read = 1'b0;
		step();
		chk8(reg_rdata, e);
	endtask : chkrd

	task automatic adv();
		colour_advance = 1'b1;
		step();
		colour_advance = 1'b0;
		step();
	endtask : adv

	task automatic chk_defaults();
		chkrd(6'h01, 8'h03);
		chkrd(6'h02, 8'h20);
		chkrd(6'h03, 8'h1f);
		chkrd(6'h06, 8'h00);
		chkrd(6'h09, 8'h00);
	endtask : chk_defaults

	// Tick rate, then edges from a new code's sampling to data_out
	task automatic lat(input logic [1:0] d, input logic inv,
			input logic fast);
		logic [11:0] e;
		int          n;
		int          t;
		fast_line_mode = fast;
		wr(6'h02, {d, 3'b100, inv, 2'b00});
		seed = lfsr(seed);
		word = seed[11:0];
		t = 0;
		for (n = 0; n < 12; n++) begin
			step();
			if (adc_tick === 1'b1) t++;
		end
		chk8(8'(t), fast ? 8'h04 : 8'h06);
		repeat (12) step();
		word = ~word;
		e = inv ? ~word : word;
		for (n = 0; n < 8 && pixel_in !== word; n++) step();
		for (n = 0; n < 4 && adc_tick !== 1'b1; n++) step();
		step();
		for (n = 0; n < 16 && data_out !== e; n++) step();
		chk8(8'(n), 8'(1 + d * (fast ? 3 : 2)));
		chk12(data_out, e);
	endtask : lat

	// Expected word part for a format and phase, high part first
	function automatic logic [11:0] part(input logic [1:0] f,
			input int ph, input logic [11:0] w);
		if (f == 2'h1) begin
			return (ph == 0) ? {w[11:4], 4'h0} : {w[3:0], 8'h00};
		end else if (f == 2'h2) begin
			return (ph == 0) ? w : {w[5:0], 6'h00};
		end else if (f == 2'h3) begin
			return (ph == 0) ? w : (ph == 1) ? {w[7:0], 4'h0}
			                                 : {w[3:0], 8'h00};
		end
		return w;
	endfunction : part

	// Multiplexed parts over one converter period, steady word
	task automatic fmt(input logic [1:0] f, input logic fast);
		int p;
		int per;
		per = fast ? 3 : 2;
		fast_line_mode = fast;
		wr(6'h02, {6'b001000, f});
		seed = lfsr(seed);
		word = seed[11:0];
		repeat (12) step();
		for (p = 0; p < 4 && adc_tick !== 1'b1; p++) step();
		step();
		for (p = 0; p < per; p++) begin
			chk12(data_out, part(f, (p + per - 1) % per, word));
			step();
		end
	endtask : fmt

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// ==================================================
	// Main sequence
	initial begin
		int         k;
		logic [7:0] v;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		step();
		chk_defaults();
		chk8(8'(ctrl.reset_timing), 8'h01);
		chk8(8'(ctrl.clamp_level), 8'h0f);
		for (k = 0; k < 40; k++) begin
			seed = lfsr(seed);
			v = seed[7:0] & keeps[k % 5];
			wr(regs[k % 5], v);
			chkrd(regs[k % 5], v & masks[k % 5]);
		end
		wr(6'h04, seed[15:8]);
		chk_defaults();
		wr(6'h0c, 8'hff);
		chkrd(6'h0c, 8'h00);
		chkrd(6'h05, 8'h00);
		chkrd(6'h07, 8'h5a);
		for (k = 0; k < 4; k++) begin
			wr(6'h01, 8'(k * 16 + 3));
			chk8(8'(ctrl.offset_mode), 8'((k < 2) ? 0 : k - 1));
		end
		wr(6'h01, 8'h45);
		v = 8'({ctrl.max_speed, ctrl.double_sample, ctrl.mono});
		chk8(v, 8'h05);
		wr(6'h01, 8'h02);
		chk8(8'({ctrl.device_active, ctrl.block_off}), 8'h0f);
		wr(6'h09, 8'h05);
		wr(6'h01, 8'h0b);
		chk8(8'(ctrl.block_off), 8'h05);
		wr(6'h01, 8'h03);
		chk8(8'(ctrl.block_off), 8'h00);
		wr(6'h02, 8'h28);
		v = 8'({ctrl.clamp_dac_oe_n, ctrl.clamp_span_top});
		chk8(v, 8'h03);
		wr(6'h02, 8'h00);
		v = 8'({ctrl.clamp_dac_oe_n, ctrl.clamp_span_top});
		chk8(v, 8'h00);
		wr(6'h03, 8'h9f);
		chk8(8'({ctrl.mono, ctrl.mono_channel}), 8'h02);
		wr(6'h06, 8'h01);
		v = 8'({ctrl.mono, ctrl.mono_channel, ctrl.block_off[2:1]});
		chk8(v, 8'h13);
		wr(6'h06, 8'h00);
		adv();
		adv();
		chk8(8'(colour_sel), 8'h04);
		wr(6'h05, seed[23:16]);
		chk8(8'(colour_sel), 8'h01);
		lat(2'h0, 1'b0, 1'b0);
		lat(2'h1, 1'b1, 1'b0);
		lat(2'h2, 1'b0, 1'b0);
		lat(2'h3, 1'b1, 1'b0);
		lat(2'h1, 1'b0, 1'b1);
		lat(2'h3, 1'b1, 1'b1);
		fmt(2'h1, 1'b0);
		fmt(2'h2, 1'b0);
		fmt(2'h3, 1'b1);
		give_verdict();
	end

	// Watchdog: tests need about 500 cycles, this allows 12500
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
endmodule : afesc_regs_bench
`default_nettype wire
